// ### core/sep_eeprom_write.sv
// sep_eeprom_write: serial eeprom page write path with block and hardware write protection.
// assumes sck, csN, si and protPinN come from outside ref_clk's domain; register port is synchronous.
//
// Operation
// R01 - write frame: opcode, 16-bit address, then data bytes, all msb first
// R02 - later bytes accepted in sequence; one write alters at most 32 bytes of one page
// R03 - pages are aligned: five low address bits run 00000 to 11111
// R04 - pointer wraps from page end to page start, page bits kept
// R05 - over 32 bytes sent: only the last 32 kept, later overwrite earlier
// R06 - locations in the guarded region are never programmed
// R07 - unguarded locations are programmed only with the write latch set
// R08 - finishing an internal write clears the write latch
// R09 - hardware protection never restricts array programming
// R10 - latch clear: array and protection fields are read-only
// R11 - arm set and pin low: protection fields read-only, array still writable
// R12 - pin high: hardware protection off, fields writable with latch set
// R13 - only address bits 11..0 select; bits 15..12 ignored
// R14 - write opcode is 0000x010 with bit 3 ignored
// R15 - host raises chip select after the last bit, before the next sck rise
// R16 - during an internal write every command but status read is ignored
// R17 - host sets the write latch before any modification
// R18 - internal write starts only on a byte boundary after a full data byte
`timescale 1ns/1ps
module sep_eeprom_write #(
  parameter int WRITE_CYCLES = sep_pkg::WC_CYCLES
) (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // serial link pins
  input  wire logic        sck,
  input  wire logic        csN,
  input  wire logic        si,
  input  wire logic        protPinN,
  // register port
  input  wire logic [7:0]  regAddr,
  input  wire logic [31:0] regWrData,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [31:0] regRdData,
  // state
  output logic             writeBusy,
  output logic             writeLatch
);

  // synchronisers: stage 1 feeds stage 2 only
  logic [3:0] syncA_r, syncB_r, syncA_nxt, syncB_nxt;
  logic       sckDly_r, csDly_r, sckDly_nxt, csDly_nxt;
  logic       sckS, csS, siS, wpS;
  logic       sckRise, csRise, csFall;

  // frame decoder state
  sep_pkg::sep_frame_t frame_r, frame_nxt;
  logic [2:0]  bitCnt_r, bitCnt_nxt;
  logic [7:0]  shift_r, shift_nxt;
  logic [7:0]  opcode_r, opcode_nxt;
  logic [7:0]  addrHi_r, addrHi_nxt;
  logic        adrCnt_r, adrCnt_nxt;
  logic [6:0]  page_r, page_nxt;
  logic [4:0]  ptr_r, ptr_nxt;
  logic        dataSeen_r, dataSeen_nxt;
  logic [7:0]  stsByte_r, stsByte_nxt;
  logic [31:0] mask_r, mask_nxt;
  logic [7:0]  rxByte;
  logic        byteDone, bufWe, isWrOp, stsCand, startArr, startSt, latchSet, latchClr, frameOk;

  // write engine state
  sep_pkg::sep_eng_t eng_r, eng_nxt;
  logic [4:0]  idx_r, idx_nxt;
  logic [sep_pkg::WC_CNT_W-1:0] wcCnt_r, wcCnt_nxt;
  logic        latch_r, latch_nxt;
  logic        isSts_r, isSts_nxt;
  sep_pkg::sep_prot_t prot_r, prot_nxt;
  logic        memWe, hwProt;
  logic [11:0] memAddr;

  // register port state
  logic [11:0] arrAddr_r, arrAddr_nxt;
  logic [31:0] rdData_r, rdData_nxt;
  logic        busy_r, busy_nxt;

  // storage
  logic [7:0]  pageBuf [sep_pkg::PAGE_BYTES];
  logic [7:0]  arrMem  [sep_pkg::ARR_BYTES];

  localparam logic [sep_pkg::WC_CNT_W-1:0] WC_LAST = sep_pkg::WC_CNT_W'(WRITE_CYCLES - 1);

  // guarded region for each guard level
  function automatic logic isProt(input sep_pkg::sep_prot_t p, input logic [11:0] a);
    unique case ({p.guardHi, p.guardLo})
      2'b00:   isProt = 1'b0;
      2'b01:   isProt = (a[11:10] == 2'b11);
      2'b10:   isProt = a[11];
      default: isProt = 1'b1;
    endcase
  endfunction

  // pin sampling; edges are found only on the second stage and its delay
  always_comb
  begin
    syncA_nxt   = {sck, csN, si, protPinN};
    syncB_nxt   = syncA_r;
    sckDly_nxt  = sckS;
    csDly_nxt   = csS;
  end

  assign sckS    = syncB_r[3];
  assign csS     = syncB_r[2];
  assign siS     = syncB_r[1];
  assign wpS     = syncB_r[0];
  assign sckRise = sckS & ~sckDly_r & ~csS;
  assign csRise  = csS & ~csDly_r;
  assign csFall  = ~csS & csDly_r;
  assign hwProt  = prot_r.arm & ~wpS;

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      // idle pin levels, protect pin released, so no false edge or guard follows reset
      syncA_r  <= 4'h7;
      syncB_r  <= 4'h7;
      sckDly_r <= 1'b0;
      csDly_r  <= 1'b1;
    end
    else
    begin
      syncA_r  <= syncA_nxt;
      syncB_r  <= syncB_nxt;
      sckDly_r <= sckDly_nxt;
      csDly_r  <= csDly_nxt;
    end
  end

  // frame decoder: shifts bytes in and decides at chip select rise
  assign rxByte   = {shift_r[6:0], siS};                                            // R01
  assign byteDone = sckRise && (bitCnt_r == 3'h7);
  assign isWrOp   = ((opcode_r & sep_pkg::OPC_MASK) == sep_pkg::OPC_WRITE);       // R14
  assign bufWe    = byteDone && (frame_r == sep_pkg::FR_DATA) && isWrOp;
  // busy frames were already dropped at their start; recheck for a late start
  assign frameOk  = (frame_r == sep_pkg::FR_DATA) && (bitCnt_r == 3'h0) && (eng_r == sep_pkg::WE_IDLE); // R16 R18
  assign startArr = csRise && frameOk && isWrOp && dataSeen_r && latch_r;          // R07 R10 R18
  assign stsCand  = ((opcode_r & sep_pkg::OPC_MASK) == sep_pkg::OPC_STATUS_WR) && dataSeen_r;
  assign startSt  = csRise && frameOk && stsCand && latch_r && !hwProt;           // R10 R11 R12
  assign latchSet = csRise && frameOk && !dataSeen_r &&
                    ((opcode_r & sep_pkg::OPC_MASK) == sep_pkg::OPC_SET_LATCH);
  assign latchClr = csRise && frameOk && !dataSeen_r &&
                    ((opcode_r & sep_pkg::OPC_MASK) == sep_pkg::OPC_CLR_LATCH);

  always_comb
  begin
    frame_nxt    = frame_r;
    bitCnt_nxt   = bitCnt_r;
    shift_nxt    = shift_r;
    opcode_nxt   = opcode_r;
    addrHi_nxt   = addrHi_r;
    adrCnt_nxt   = adrCnt_r;
    page_nxt     = page_r;
    ptr_nxt      = ptr_r;
    dataSeen_nxt = dataSeen_r;
    stsByte_nxt  = stsByte_r;
    mask_nxt     = mask_r;
    if (csFall)
    begin
      frame_nxt    = (eng_r != sep_pkg::WE_IDLE) ? sep_pkg::FR_DROP : sep_pkg::FR_OPCODE; // R16
      bitCnt_nxt   = 3'h0;
      adrCnt_nxt   = 1'b0;
      dataSeen_nxt = 1'b0;
    end
    else if (csS)
      frame_nxt = sep_pkg::FR_IDLE;
    else if (sckRise)
    begin
      shift_nxt  = rxByte;
      bitCnt_nxt = bitCnt_r + 3'h1;
      if (byteDone)
      begin
        unique case (frame_r)
          sep_pkg::FR_OPCODE:
          begin
            opcode_nxt = rxByte;
            frame_nxt  = ((rxByte & sep_pkg::OPC_MASK) == sep_pkg::OPC_WRITE) ? sep_pkg::FR_ADDR
                                                                             : sep_pkg::FR_DATA; // R14
          end
          sep_pkg::FR_ADDR:
          begin
            adrCnt_nxt = 1'b1;
            addrHi_nxt = rxByte;
            if (adrCnt_r)
            begin
              page_nxt  = {addrHi_r[3:0], rxByte[7:5]};                           // R03 R13
              ptr_nxt   = rxByte[4:0];
              mask_nxt  = 32'h0000_0000;
              frame_nxt = sep_pkg::FR_DATA;
            end
          end
          sep_pkg::FR_DATA:
          begin
            dataSeen_nxt = 1'b1;
            stsByte_nxt  = rxByte;
            if (isWrOp)
            begin
              mask_nxt[ptr_r] = 1'b1;                                              // R02 R05
              ptr_nxt         = ptr_r + 5'h01;                                     // R04
            end
          end
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      frame_r    <= sep_pkg::FR_IDLE;
      bitCnt_r   <= 3'h0;
      shift_r    <= 8'h00;
      opcode_r   <= 8'h00;
      addrHi_r   <= 8'h00;
      adrCnt_r   <= 1'b0;
      page_r     <= 7'h00;
      ptr_r      <= 5'h00;
      dataSeen_r <= 1'b0;
      stsByte_r  <= 8'h00;
      mask_r     <= 32'h0000_0000;
    end
    else
    begin
      frame_r    <= frame_nxt;
      bitCnt_r   <= bitCnt_nxt;
      shift_r    <= shift_nxt;
      opcode_r   <= opcode_nxt;
      addrHi_r   <= addrHi_nxt;
      adrCnt_r   <= adrCnt_nxt;
      page_r     <= page_nxt;
      ptr_r      <= ptr_nxt;
      dataSeen_r <= dataSeen_nxt;
      stsByte_r  <= stsByte_nxt;
      mask_r     <= mask_nxt;
    end
  end

  // write engine: copies the page buffer for array writes, then waits out the cycle time
  assign memAddr = {page_r, idx_r};
  // arm bit and pin play no part here, only guard level and byte mask
  assign memWe   = (eng_r == sep_pkg::WE_COMMIT) && mask_r[idx_r] && !isProt(prot_r, memAddr); // R06 R09

  always_comb
  begin
    eng_nxt   = eng_r;
    idx_nxt   = idx_r;
    wcCnt_nxt = wcCnt_r;
    latch_nxt = latch_r;
    isSts_nxt = isSts_r;
    prot_nxt  = prot_r;
    if (latchSet)
      latch_nxt = 1'b1;
    if (latchClr)
      latch_nxt = 1'b0;
    unique case (eng_r)
      sep_pkg::WE_IDLE:
      begin
        idx_nxt   = 5'h00;
        wcCnt_nxt = '0;
        if (startArr)
        begin
          eng_nxt   = sep_pkg::WE_COMMIT;
          isSts_nxt = 1'b0;
        end
        else if (startSt)
        begin
          eng_nxt   = sep_pkg::WE_WAIT;
          isSts_nxt = 1'b1;
        end
      end
      sep_pkg::WE_COMMIT:
      begin
        idx_nxt = idx_r + 5'h01;
        if (idx_r == 5'h1f)
          eng_nxt = sep_pkg::WE_WAIT;                                              // R02
      end
      sep_pkg::WE_WAIT:
      begin
        wcCnt_nxt = wcCnt_r + 1'b1;
        if (wcCnt_r >= WC_LAST)
        begin
          eng_nxt   = sep_pkg::WE_IDLE;
          latch_nxt = 1'b0;                                                        // R08
          // fields change only once the cycle has completed
          if (isSts_r)
            prot_nxt = '{arm: stsByte_r[sep_pkg::ST_ARM], guardHi: stsByte_r[sep_pkg::ST_GHI],
                         guardLo: stsByte_r[sep_pkg::ST_GLO]};                    // R11 R12
        end
      end
      default: eng_nxt = sep_pkg::WE_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      eng_r   <= sep_pkg::WE_IDLE;
      idx_r   <= 5'h00;
      wcCnt_r <= '0;
      latch_r <= 1'b0;
      isSts_r <= 1'b0;
      prot_r  <= sep_pkg::PROT_RST;
    end
    else
    begin
      eng_r   <= eng_nxt;
      idx_r   <= idx_nxt;
      wcCnt_r <= wcCnt_nxt;
      latch_r <= latch_nxt;
      isSts_r <= isSts_nxt;
      prot_r  <= prot_nxt;
    end
  end

  // storage writes; no reset, contents are data, not control
  always_ff @(posedge ref_clk)
  begin
    if (bufWe)
      pageBuf[ptr_r] <= rxByte;                                                    // R05
    if (memWe)
      arrMem[memAddr] <= pageBuf[idx_r];                                           // R06 R07
  end

  // register port: read data one cycle after the strobe, zero elsewhere
  always_comb
  begin
    arrAddr_nxt = arrAddr_r;
    rdData_nxt  = 32'h0000_0000;
    busy_nxt    = (eng_nxt != sep_pkg::WE_IDLE);
    if (regWr && regAddr == sep_pkg::REG_ARR_ADDR)
      arrAddr_nxt = regWrData[11:0];
    if (regRd)
    begin
      unique case (regAddr)
        sep_pkg::REG_STATUS:
        begin
          rdData_nxt[sep_pkg::ST_BUSY]  = busy_r;
          rdData_nxt[sep_pkg::ST_LATCH] = latch_r;
          rdData_nxt[sep_pkg::ST_GLO]   = prot_r.guardLo;
          rdData_nxt[sep_pkg::ST_GHI]   = prot_r.guardHi;
          rdData_nxt[sep_pkg::ST_ARM]   = prot_r.arm;
        end
        sep_pkg::REG_ARR_ADDR: rdData_nxt[11:0] = arrAddr_r;
        sep_pkg::REG_ARR_DATA: rdData_nxt[7:0]  = arrMem[arrAddr_r];
        default:               rdData_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      arrAddr_r <= 12'h000;
      rdData_r  <= 32'h0000_0000;
      busy_r    <= 1'b0;
    end
    else
    begin
      arrAddr_r <= arrAddr_nxt;
      rdData_r  <= rdData_nxt;
      busy_r    <= busy_nxt;
    end
  end

  assign regRdData  = rdData_r;
  assign writeBusy  = busy_r;
  assign writeLatch = latch_r;

  // checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  sequence sCommitStart;
    $rose(eng_r == sep_pkg::WE_COMMIT);
  endsequence

  sequence sCommitEnd;
    ##31 (eng_r == sep_pkg::WE_COMMIT) ##1 (eng_r == sep_pkg::WE_WAIT);
  endsequence

  commit_length_a: assert property (sCommitStart |-> sCommitEnd) // R02
    else $error("commit did not last 32 cycles");
  page_wrap_a: assert property ((bufWe && ptr_r == 5'h1f) |=> (ptr_r == 5'h00) && $stable(page_r)) // R04
    else $error("pointer did not wrap inside the page");
  // region decoded apart from isProt so a slip in that function shows up here
  block_guard_a: assert property (memWe |-> !(prot_r.guardHi && prot_r.guardLo) && // R06
                                  !(prot_r.guardHi && memAddr[11]) &&
                                  !(prot_r.guardLo && (memAddr[11:10] == 2'b11)))
    else $error("guarded location programmed");
  page_select_a: assert property (memWe |-> (memAddr[11:5] == page_r) && mask_r[idx_r]) // R13
    else $error("write outside the selected page");
  latch_gate_a: assert property (sCommitStart |-> latch_r && $past(startArr)) // R07
    else $error("array write started without latch");
  latch_clear_a: assert property ((eng_r == sep_pkg::WE_WAIT) ##1 (eng_r == sep_pkg::WE_IDLE) |-> !latch_r) // R08
    else $error("latch survived write completion");
  hw_status_a: assert property (startSt |-> !(prot_r.arm && !wpS) && latch_r) // R10
    else $error("status write under hardware protection");
  pin_release_a: assert property ((csRise && frameOk && stsCand && latch_r && wpS) |=> eng_r == sep_pkg::WE_WAIT) // R12
    else $error("status write refused with pin high");
  busy_ignore_a: assert property ((eng_r != sep_pkg::WE_IDLE) |=> !$rose(latch_r)) // R16
    else $error("command taken while busy");
  byte_edge_a: assert property ((csRise && (bitCnt_r != 3'h0) && (eng_r == sep_pkg::WE_IDLE)) |=> (eng_r == sep_pkg::WE_IDLE)) // R18
    else $error("write started off a byte boundary");
  opcode_form_a: assert property ((frame_r == sep_pkg::FR_ADDR) |-> isWrOp) // R14
    else $error("address phase without write opcode");

endmodule

// ### pkg/sep_pkg.sv
// sep_pkg: constants, types and register map of the eeprom page-write block.
// assumes a 100 MHz ref_clk and a serial link sampled by that clock.
package sep_pkg;

  // array geometry
  localparam int ADDR_W     = 12;
  localparam int DATA_W     = 8;
  localparam int PAGE_BYTES = 32;
  localparam int PTR_W      = 5;
  localparam int ARR_BYTES  = 4096;

  // instruction codes; bit 3 is don't-care and masked off
  localparam logic [7:0] OPC_MASK      = 8'hf7;
  localparam logic [7:0] OPC_WRITE     = 8'h02;
  localparam logic [7:0] OPC_SET_LATCH = 8'h06;
  localparam logic [7:0] OPC_CLR_LATCH = 8'h04;
  localparam logic [7:0] OPC_STATUS_WR = 8'h01;

  // register offsets (byte addresses)
  localparam logic [7:0] REG_STATUS   = 8'h00;
  localparam logic [7:0] REG_ARR_ADDR = 8'h04;
  localparam logic [7:0] REG_ARR_DATA = 8'h08;

  // status field positions, shared by the status word and the status byte
  localparam int ST_BUSY  = 0;
  localparam int ST_LATCH = 1;
  localparam int ST_GLO   = 2;
  localparam int ST_GHI   = 3;
  localparam int ST_ARM   = 7;

  // timing: write cycle time and clock period in ns
  localparam int T_WC_NS        = 5000000;
  localparam int CLK_PERIOD_NS  = 10;
  localparam int WC_CYCLES      = T_WC_NS / CLK_PERIOD_NS;
  localparam int WC_CNT_W       = 20;

  // protection fields held by the status register
  typedef struct packed {
    logic arm;
    logic guardHi;
    logic guardLo;
  } sep_prot_t;

  localparam sep_prot_t PROT_RST = '{arm: 1'b0, guardHi: 1'b0, guardLo: 1'b0};

  // serial frame decoder and internal write engine states
  typedef enum logic [2:0] {FR_IDLE, FR_OPCODE, FR_ADDR, FR_DATA, FR_DROP} sep_frame_t;
  typedef enum logic [1:0] {WE_IDLE, WE_COMMIT, WE_WAIT} sep_eng_t;

endpackage

// ### tb/sep_host_model.sv
// sep_host_model: behavioural serial host that drives the eeprom link pins.
// assumes the bench spaces frames and never calls frame twice at once; sck idles low.
`timescale 1ns/1ps
module sep_host_model #(
  parameter int HALF_NS = 80
) (
  // serial link pins
  output logic sck,
  output logic csN,
  output logic si
);
  // idle levels at time zero
  initial
  begin
    sck = 1'b0;
    csN = 1'b1;
    si  = 1'b1;
  end

  // one frame: whole bytes msb first, then extraBits stray bits of a filler byte
  task automatic frame(input logic [7:0] bytes[$], input int extraBits);
    logic [7:0] cur;
    // step off the ref_clk edge so the pins never race the sampling flops
    #2;
    csN = 1'b0;
    #(HALF_NS);
    for (int i = 0; i < bytes.size() + (extraBits > 0); i++)
    begin
      cur = (i < bytes.size()) ? bytes[i] : 8'ha5;
      for (int b = 7; b >= 0; b--)
      begin
        if (i == bytes.size() && b < 8 - extraBits)
          break;
        si = cur[b];
        #(HALF_NS);
        sck = 1'b1;
        #(HALF_NS);
        sck = 1'b0;
      end
    end
    #(HALF_NS / 2);
    csN = 1'b1;
    si  = ~si;  // released line must not keep showing the last bit
    #(HALF_NS * 4);
  endtask
endmodule

// ### tb/sep_eeprom_write_bench.sv
// sep_eeprom_write_bench: self-checking bench for the page write and protection path.
// assumes the host model drives the link; array bytes are read back over the register port.
`timescale 1ns/1ps
module sep_eeprom_write_bench;
  // short write cycle keeps the run brief; busy still outlasts one latch frame
  localparam int WC = 400;
  localparam logic [7:0] OPW = sep_pkg::OPC_WRITE;

  logic        ref_clk;
  logic        rst;
  logic        sck;
  logic        csN;
  logic        si;
  logic        protPinN;
  logic [7:0]  regAddr;
  logic [31:0] regWrData;
  logic        regWr;
  logic        regRd;
  logic [31:0] regRdData;
  logic        writeBusy;
  logic        writeLatch;
  logic [31:0] rd;
  logic [7:0]  q[$];
  int          n_errors   = 0;
  int          n_compared = 0;

  sep_eeprom_write #(.WRITE_CYCLES(WC)) sep_eeprom_write_i (
    .ref_clk(ref_clk), .rst(rst), .sck(sck), .csN(csN), .si(si), .protPinN(protPinN),
    .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .writeBusy(writeBusy), .writeLatch(writeLatch)
  );

  sep_host_model sep_host_model_i (.sck(sck), .csN(csN), .si(si));

  // 100 MHz clock
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic print_verdict;
    if (n_errors == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // register port: one-cycle strobes, read data taken in the following cycle
  task automatic regWrite(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    regAddr   <= a;
    regWrData <= d;
    regWr     <= 1'b1;
    @(posedge ref_clk);
    regWr <= 1'b0;
  endtask

  task automatic regRead(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge ref_clk);
    regRd <= 1'b0;
    #1 d = regRdData;
  endtask

  task automatic chkByte(input logic [11:0] a, input logic [7:0] exp);
    regWrite(sep_pkg::REG_ARR_ADDR, {20'h0, a});
    regRead(sep_pkg::REG_ARR_DATA, rd);
    chk($sformatf("byte %h", a), rd, {24'h0, exp});
  endtask

  // let the frame land, then wait out any internal write under a bound
  task automatic settle;
    repeat (10) @(posedge ref_clk);
    for (int i = 0; i < 1000 && writeBusy !== 1'b0; i++)
      @(posedge ref_clk);
    chk("busy end", {31'h0, writeBusy}, 32'h0);
  endtask

  task automatic setLatch;
    sep_host_model_i.frame({sep_pkg::OPC_SET_LATCH}, 0);
    settle();
    chk("latch set", {31'h0, writeLatch}, 32'h1);
  endtask

  task automatic arrWrite(input logic [7:0] opc, input logic [15:0] a, input logic [7:0] d[$], input int extra);
    logic [7:0] f[$];
    f = {opc, a[15:8], a[7:0]};
    f = {f, d};
    sep_host_model_i.frame(f, extra);
  endtask

  task automatic statusWrite(input logic [7:0] d);
    sep_host_model_i.frame({sep_pkg::OPC_STATUS_WR, d}, 0);
    settle();
  endtask

  task automatic chkFields(input logic [31:0] exp);
    regRead(sep_pkg::REG_STATUS, rd);
    chk("status fields", rd & 32'h8c, exp);
  endtask

  // hang guard: the whole sequence needs well under half a millisecond
  initial
  begin
    #(600000);
    n_errors++;
    print_verdict();
  end

  initial
  begin
    rst = 1'b1;
    protPinN = 1'b1;
    regAddr = 8'h00;
    regWrData = 32'h0;
    regWr = 1'b0;
    regRd = 1'b0;
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    // reset state, read-only status and an unmapped offset
    regWrite(sep_pkg::REG_STATUS, 32'hff);
    regRead(sep_pkg::REG_STATUS, rd);
    chk("status reset", rd, 32'h0);
    regRead(8'h10, rd);
    chk("unmapped", rd, 32'h0);
    // two bytes, upper address bits set; a latch frame during busy is ignored
    setLatch();
    arrWrite(OPW, 16'hf040, {8'hab, 8'hcd}, 0);
    repeat (6) @(posedge ref_clk);
    chk("busy", {31'h0, writeBusy}, 32'h1);
    sep_host_model_i.frame({sep_pkg::OPC_SET_LATCH}, 0);
    settle();
    chk("latch after write", {31'h0, writeLatch}, 32'h0);
    chkByte(12'h040, 8'hab);
    chkByte(12'h041, 8'hcd);
    // write with latch, then a second write without latch that is refused
    setLatch();
    arrWrite(OPW, 16'h0060, {8'h22}, 0);
    settle();
    arrWrite(OPW, 16'h0060, {8'h11}, 0);
    settle();
    chkByte(12'h060, 8'h22);
    // clear-latch command, then a write that must be refused
    setLatch();
    sep_host_model_i.frame({sep_pkg::OPC_CLR_LATCH}, 0);
    settle();
    chk("latch cleared", {31'h0, writeLatch}, 32'h0);
    arrWrite(OPW, 16'h0060, {8'h99}, 0);
    settle();
    chkByte(12'h060, 8'h22);
    setLatch();
    arrWrite(OPW, 16'h0060, {8'h55}, 3);
    settle();
    chkByte(12'h060, 8'h22);
    // 34 bytes from offset 30 with opcode bit 3 set: wrap, last 32 kept
    setLatch();
    for (int i = 0; i < 34; i++)
      q.push_back(8'(i + 1));
    arrWrite(OPW | 8'h08, 16'h01fe, q, 0);
    settle();
    chkByte(12'h1e0, 8'h03);
    chkByte(12'h1fd, 8'h20);
    chkByte(12'h1fe, 8'h21);
    chkByte(12'h1ff, 8'h22);
    // guard the top quarter and arm hardware protection with the pin high
    setLatch();
    arrWrite(OPW, 16'h0c10, {8'h33}, 0);
    settle();
    setLatch();
    statusWrite(8'h84);
    chkFields(32'h84);
    // read data stands one cycle only
    @(posedge ref_clk);
    #1 chk("read data cleared", regRdData, 32'h0);
    chk("latch after status", {31'h0, writeLatch}, 32'h0);
    setLatch();
    arrWrite(OPW, 16'h0c10, {8'h77}, 0);
    settle();
    chkByte(12'hc10, 8'h33);
    // pin low: array still writable, protection fields frozen
    @(posedge ref_clk);
    protPinN <= 1'b0;
    setLatch();
    arrWrite(OPW, 16'h0010, {8'h44}, 0);
    settle();
    chkByte(12'h010, 8'h44);
    setLatch();
    statusWrite(8'h00);
    chkFields(32'h84);
    // pin high again: fields writable with latch, frozen without
    @(posedge ref_clk);
    protPinN <= 1'b1;
    setLatch();
    statusWrite(8'h00);
    chkFields(32'h00);
    statusWrite(8'h0c);
    chkFields(32'h00);
    print_verdict();
  end
endmodule
